// ===== logic/byte_packer_consts.vh
`ifndef BYTE_PACKER_CONSTS_VH
`define BYTE_PACKER_CONSTS_VH
////////////////////////////////////////////////////////////////////////////////
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_SENSE0 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10
////////////////////////////////////////////////////////////////////////////////
`define CTRL_TRK7_BIT 0
`define CTRL_CONV_BIT 1
`define CTRL_OP_LSB 2
`define CTRL_OP_MSB 3
`define OP_IDLE 2'h0
`define OP_WRITE 2'h1
`define OP_READ_FWD 2'h2
`define OP_READ_BWD 2'h3
`define STAT_BUSY_BIT 0
`define STAT_UNIT_CHK_BIT 1
`define STAT_CONV_ACT_BIT 2
`define SENSE0_CONV_CHK_BIT 7
`define IRQ_DONE_BIT 0
`define IRQ_CHK_BIT 1
`define IRQ_RESET 2'h0
`define CTRL_TRK7_RESET 1'h0
`define CTRL_CONV_RESET 1'h0
`endif

// ===== logic/tail_checker.v
`timescale 1ns/1ps
`default_nettype none
module tail_checker (
  input wire [1:0] rem,
  input wire [5:0] final_char,
  output reg bad
);
  // rem is the character count of the block modulo four
  always @* begin
    case (rem)
      2'h1: bad = 1'b1;
      2'h2: bad = |final_char[3:0];
      2'h3: bad = |final_char[1:0];
      default: bad = 1'b0;
    endcase
  end
endmodule // tail_checker
`default_nettype wire

// ===== logic/seven_track_byte_packer.v
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "byte_packer_consts.vh"
module seven_track_byte_packer (
  input wire CLK_SYS,
  input wire SRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire BYTE_IN_VALID,
  output wire BYTE_IN_READY,
  input wire [7:0] BYTE_IN_DATA,
  input wire BYTE_IN_LAST,
  output wire CHAR_OUT_VALID,
  input wire CHAR_OUT_READY,
  output wire [5:0] CHAR_OUT_DATA,
  output wire CHAR_OUT_LAST,
  input wire CHAR_IN_VALID,
  output wire CHAR_IN_READY,
  input wire [5:0] CHAR_IN_DATA,
  input wire CHAR_IN_LAST,
  output wire BYTE_OUT_VALID,
  input wire BYTE_OUT_READY,
  output wire [7:0] BYTE_OUT_DATA,
  output wire BYTE_OUT_LAST,
  output wire IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // states, one-hot
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_FILL = 3'h2;
  localparam [2:0] S_EMIT = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // functions

  // left-justify the valid low bits of the group
  function [23:0] justify;
    input [23:0] acc;
    input [2:0] n;
    input wr;
    reg [4:0] nbits;
    begin
      nbits = wr ? {n[1:0], 3'h0} : ({2'h0, n} << 2) + ({2'h0, n} << 1);
      justify = acc << (5'd24 - nbits);
    end
  endfunction

  // number of output units for a group of n input units
  function [2:0] out_units;
    input [2:0] n;
    input wr;
    input conv;
    begin
      if (!conv) begin
        out_units = 3'h1;
      end else if (wr) begin
        out_units = n + 3'h1;
      end else begin
        case (n)
          3'h4: out_units = 3'h3;
          3'h3: out_units = 3'h2;
          3'h2: out_units = 3'h1;
          default: out_units = 3'h0;
        endcase
      end
    end
  endfunction

  // one aligned word per register offset
  function reg_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // drop the unit just handed over, the next one moves to the top
  function [23:0] shift_word;
    input [23:0] w;
    input wr;
    begin
      shift_word = wr ? {w[17:0], 6'h0} : {w[15:0], 8'h0};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  reg trk7_r;
  reg conv_en_r;
  reg [1:0] op_r;
  reg [2:0] state_r;
  reg [23:0] acc_r;
  reg [2:0] cnt_r;
  reg [23:0] word_r;
  reg [2:0] left_r;
  reg last_r;
  reg conv_chk_r;
  reg unit_chk_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [31:0] prdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // operation decode
  wire is_wr;
  wire is_rd;
  wire conv_on;
  assign is_wr = (op_r == `OP_WRITE);
  assign is_rd = (op_r == `OP_READ_FWD) || (op_r == `OP_READ_BWD);
  // read-backward never converts, yet the enable bit stays untouched
  assign conv_on = trk7_r & conv_en_r &
    ((op_r == `OP_WRITE) || (op_r == `OP_READ_FWD));

  ////////////////////////////////////////////////////////////////////////////////
  // input side
  wire in_ready;
  wire in_valid;
  wire in_last;
  wire take;
  wire [23:0] acc_nxt;
  wire [2:0] cnt_inc;
  wire grp_full;
  wire [2:0] n_out;
  wire [23:0] word_nxt;

  assign in_ready = state_r[1] & (is_wr | is_rd);
  assign BYTE_IN_READY = in_ready & is_wr;
  assign CHAR_IN_READY = in_ready & is_rd;
  assign in_valid = is_wr ? BYTE_IN_VALID : CHAR_IN_VALID;
  assign in_last = is_wr ? BYTE_IN_LAST : CHAR_IN_LAST;
  assign take = in_ready & in_valid;

  // msb first: older units sit higher in the group word
  assign acc_nxt = is_wr ? {acc_r[15:0], BYTE_IN_DATA} : {acc_r[17:0], CHAR_IN_DATA};
  assign cnt_inc = cnt_r + 3'h1;
  assign grp_full = !conv_on || (is_wr ? (cnt_inc == 3'h3) : (cnt_inc == 3'h4));
  assign n_out = out_units(cnt_inc, is_wr, conv_on);

  // zero fill below the justified bits yields the padding zeros
  assign word_nxt = !conv_on ?
    (is_wr ? {acc_nxt[5:0], 18'h0} : {2'h0, acc_nxt[5:0], 16'h0}) :
    justify(acc_nxt, cnt_inc, is_wr);

  ////////////////////////////////////////////////////////////////////////////////
  // read tail check
  wire tail_bad;
  wire chk_hit;

  tail_checker u_tail (
    .rem(cnt_inc[1:0]),
    .final_char(CHAR_IN_DATA),
    .bad(tail_bad)
  );

  // only a converting forward read on 7-track can flag
  assign chk_hit = take & CHAR_IN_LAST & (op_r == `OP_READ_FWD) &
    conv_on & tail_bad;

  ////////////////////////////////////////////////////////////////////////////////
  // output side
  wire out_valid;
  wire out_ready;
  wire give;
  wire out_last;

  assign out_valid = state_r[2];
  assign CHAR_OUT_VALID = out_valid & is_wr;
  assign BYTE_OUT_VALID = out_valid & is_rd;
  assign out_ready = is_wr ? CHAR_OUT_READY : BYTE_OUT_READY;
  assign give = out_valid & out_ready;
  assign out_last = last_r & (left_r == 3'h1);
  assign CHAR_OUT_DATA = word_r[23:18];
  assign BYTE_OUT_DATA = word_r[23:16];
  assign CHAR_OUT_LAST = out_last & is_wr;
  assign BYTE_OUT_LAST = out_last & is_rd;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup;
  wire access;
  wire wr_en;
  wire mapped;
  wire wr_ctrl;
  wire wr_stat;
  wire wr_mask;
  reg [31:0] rd_val;

  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign wr_en = access & PWRITE;
  assign mapped = reg_hit(PADDR, `OFS_CTRL) || reg_hit(PADDR, `OFS_STATUS) ||
    reg_hit(PADDR, `OFS_SENSE0) || reg_hit(PADDR, `OFS_IRQ_STAT) ||
    reg_hit(PADDR, `OFS_IRQ_MASK);
  assign wr_ctrl = wr_en && reg_hit(PADDR, `OFS_CTRL);
  assign wr_stat = wr_en && reg_hit(PADDR, `OFS_IRQ_STAT);
  assign wr_mask = wr_en && reg_hit(PADDR, `OFS_IRQ_MASK);
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;
  assign PRDATA = prdata_r;

  always @* begin
    case (PADDR)
      `OFS_CTRL: rd_val = {28'h0, op_r, conv_en_r, trk7_r};
      `OFS_STATUS: rd_val = {29'h0, conv_on, unit_chk_r, ~state_r[0]};
      `OFS_SENSE0: rd_val = {24'h0, conv_chk_r, 7'h0};
      `OFS_IRQ_STAT: rd_val = {30'h0, irq_stat_r};
      `OFS_IRQ_MASK: rd_val = {30'h0, irq_mask_r};
      default: rd_val = 32'h0;
    endcase
  end

  // a new op may only be started from idle
  wire start_op;
  assign start_op = wr_ctrl && state_r[0] && (op_r == `OP_IDLE) &&
    (PWDATA[`CTRL_OP_MSB:`CTRL_OP_LSB] != `OP_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // datapath state machine
  reg [2:0] state_nxt;
  reg [1:0] op_nxt;
  reg done_ev;

  always @* begin
    state_nxt = state_r;
    op_nxt = op_r;
    done_ev = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (start_op) begin
          op_nxt = PWDATA[`CTRL_OP_MSB:`CTRL_OP_LSB];
          state_nxt = S_FILL;
        end
      end
      S_FILL: begin
        if (take && (grp_full || in_last)) begin
          if (n_out == 3'h0) begin
            // a lone trailing character gives no byte
            state_nxt = S_IDLE;
            op_nxt = `OP_IDLE;
            done_ev = 1'b1;
          end else begin
            state_nxt = S_EMIT;
          end
        end
      end
      S_EMIT: begin
        if (give && (left_r == 3'h1)) begin
          if (last_r) begin
            state_nxt = S_IDLE;
            op_nxt = `OP_IDLE;
            done_ev = 1'b1;
          end else begin
            state_nxt = S_FILL;
          end
        end
      end
      default: begin
        state_nxt = S_IDLE;
        op_nxt = `OP_IDLE;
      end
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      state_r <= S_IDLE;
      op_r <= `OP_IDLE;
      acc_r <= 24'h0;
      cnt_r <= 3'h0;
      word_r <= 24'h0;
      left_r <= 3'h0;
      last_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      if (start_op) begin
        acc_r <= 24'h0;
        cnt_r <= 3'h0;
      end else if (take) begin
        if (grp_full || in_last) begin
          acc_r <= 24'h0;
          cnt_r <= 3'h0;
          word_r <= word_nxt;
          left_r <= n_out;
          last_r <= in_last;
        end else begin
          acc_r <= acc_nxt;
          cnt_r <= cnt_inc;
        end
      end else if (give) begin
        word_r <= shift_word(word_r, is_wr);
        left_r <= left_r - 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control, sense and interrupt registers
  wire [1:0] irq_ev;
  wire [1:0] irq_clr;
  assign irq_ev = {chk_hit, done_ev};
  assign irq_clr = wr_stat ? PWDATA[1:0] : 2'h0;

  always @(posedge CLK_SYS) begin
    if (SRST) begin
      trk7_r <= `CTRL_TRK7_RESET;
      conv_en_r <= `CTRL_CONV_RESET;
      conv_chk_r <= 1'b0;
      unit_chk_r <= 1'b0;
      irq_stat_r <= `IRQ_RESET;
      irq_mask_r <= `IRQ_RESET;
      prdata_r <= 32'h0;
    end else begin
      // mode bits are frozen while a block is moving
      if (wr_ctrl && state_r[0]) begin
        trk7_r <= PWDATA[`CTRL_TRK7_BIT];
        conv_en_r <= PWDATA[`CTRL_CONV_BIT];
      end
      if (chk_hit) begin
        conv_chk_r <= 1'b1;
        unit_chk_r <= 1'b1;
      end else if (start_op) begin
        conv_chk_r <= 1'b0;
        unit_chk_r <= 1'b0;
      end
      // set beats a same-cycle clear
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
      if (wr_mask) begin
        irq_mask_r <= PWDATA[1:0];
      end
      if (setup && !PWRITE) begin
        prdata_r <= rd_val;
      end
    end
  end

  assign IRQ = |(irq_stat_r & irq_mask_r);

endmodule // seven_track_byte_packer
`default_nettype wire

// ===== verif/tape_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module tape_side_model (
  input wire logic clk,
  input wire logic slow,
  output logic char_ready,
  output logic byte_ready
);
  logic ph = 1'b0;
  initial begin
    char_ready = 1'b0;
    byte_ready = 1'b0;
  end
  // slow mode drops ready every other cycle to stall the block
  always @(posedge clk) begin
    ph <= !ph;
    char_ready <= !slow || ph;
    byte_ready <= !slow || ph;
  end
endmodule // tape_side_model
`default_nettype wire

// ===== verif/seven_track_byte_packer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module packer_checker (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic BYTE_IN_READY,
  input wire logic CHAR_IN_READY,
  input wire logic CHAR_OUT_VALID,
  input wire logic CHAR_OUT_READY,
  input wire logic [5:0] CHAR_OUT_DATA,
  input wire logic BYTE_OUT_VALID,
  input wire logic BYTE_OUT_READY,
  input wire logic [7:0] BYTE_OUT_DATA
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  sequence s_cstall; CHAR_OUT_VALID && !CHAR_OUT_READY; endsequence
  sequence s_bstall; BYTE_OUT_VALID && !BYTE_OUT_READY; endsequence
  property p_chold; s_cstall |=> CHAR_OUT_VALID && $stable(CHAR_OUT_DATA); endproperty
  a_chold: assert property (p_chold) else $error("char lost in stall");
  property p_bhold; s_bstall |=> BYTE_OUT_VALID && $stable(BYTE_OUT_DATA); endproperty
  a_bhold: assert property (p_bhold) else $error("byte lost in stall");
  property p_excl; !(BYTE_IN_READY && CHAR_IN_READY); endproperty
  a_excl: assert property (p_excl) else $error("both inputs open");
  property p_emit; CHAR_OUT_VALID |-> !BYTE_IN_READY; endproperty
  a_emit: assert property (p_emit) else $error("fill while emitting");
  property p_pack; BYTE_OUT_VALID |-> !CHAR_IN_READY; endproperty
  a_pack: assert property (p_pack) else $error("fill while packing");
  property p_dir; CHAR_OUT_VALID |-> !BYTE_OUT_VALID; endproperty
  a_dir: assert property (p_dir) else $error("both directions active");
  property p_rdy; PSEL && PENABLE |-> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access");
  property p_err; PSLVERR |-> PSEL && PENABLE; endproperty
  a_err: assert property (p_err) else $error("error outside access");
endmodule // packer_checker
bind seven_track_byte_packer packer_checker u_chk (.CLK_SYS(CLK_SYS), .SRST(SRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BYTE_IN_READY(BYTE_IN_READY), .CHAR_IN_READY(CHAR_IN_READY),
  .CHAR_OUT_VALID(CHAR_OUT_VALID), .CHAR_OUT_READY(CHAR_OUT_READY),
  .CHAR_OUT_DATA(CHAR_OUT_DATA), .BYTE_OUT_VALID(BYTE_OUT_VALID),
  .BYTE_OUT_READY(BYTE_OUT_READY), .BYTE_OUT_DATA(BYTE_OUT_DATA));
`default_nettype wire

// ===== verif/seven_track_byte_packer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "byte_packer_consts.vh"
module seven_track_byte_packer_tb_top;
  logic CLK_SYS = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic BYTE_IN_VALID = 1'b0, BYTE_IN_LAST = 1'b0, CHAR_IN_VALID = 1'b0;
  logic CHAR_IN_LAST = 1'b0, slow = 1'b0, perr;
  logic [7:0] PADDR = 8'h00, BYTE_IN_DATA = 8'h00;
  logic [31:0] PWDATA = 32'h0, rd;
  logic [5:0] CHAR_IN_DATA = 6'h00;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, BYTE_IN_READY, CHAR_OUT_VALID, CHAR_OUT_LAST, CHAR_IN_READY;
  wire BYTE_OUT_VALID, BYTE_OUT_LAST, IRQ, CHAR_OUT_READY, BYTE_OUT_READY;
  wire [5:0] CHAR_OUT_DATA;
  wire [7:0] BYTE_OUT_DATA;
  logic [6:0] cq[$];
  logic [8:0] bq[$];
  logic [7:0] bs[6] = '{8'ha5, 8'h3c, 8'hf0, 8'h81, 8'h5e, 8'h27};
  logic [5:0] cs[8] = '{6'h2b, 6'h11, 6'h3f, 6'h04, 6'h19, 6'h30, 6'h20, 6'h3c};
  int err_total = 0;
  int n_compared = 0;
  always #2.5 CLK_SYS = !CLK_SYS;
  seven_track_byte_packer dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .BYTE_IN_VALID(BYTE_IN_VALID),
    .BYTE_IN_READY(BYTE_IN_READY), .BYTE_IN_DATA(BYTE_IN_DATA), .BYTE_IN_LAST(BYTE_IN_LAST),
    .CHAR_OUT_VALID(CHAR_OUT_VALID), .CHAR_OUT_READY(CHAR_OUT_READY),
    .CHAR_OUT_DATA(CHAR_OUT_DATA), .CHAR_OUT_LAST(CHAR_OUT_LAST),
    .CHAR_IN_VALID(CHAR_IN_VALID), .CHAR_IN_READY(CHAR_IN_READY),
    .CHAR_IN_DATA(CHAR_IN_DATA), .CHAR_IN_LAST(CHAR_IN_LAST),
    .BYTE_OUT_VALID(BYTE_OUT_VALID), .BYTE_OUT_READY(BYTE_OUT_READY),
    .BYTE_OUT_DATA(BYTE_OUT_DATA), .BYTE_OUT_LAST(BYTE_OUT_LAST), .IRQ(IRQ));
  tape_side_model far (.clk(CLK_SYS), .slow(slow), .char_ready(CHAR_OUT_READY),
    .byte_ready(BYTE_OUT_READY));
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS) begin
    if (CHAR_OUT_VALID && CHAR_OUT_READY) cq.push_back({CHAR_OUT_LAST, CHAR_OUT_DATA});
    if (BYTE_OUT_VALID && BYTE_OUT_READY) bq.push_back({BYTE_OUT_LAST, BYTE_OUT_DATA});
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one idle cycle after each transfer keeps psel edges apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (!PREADY);
    rd = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic post(input logic ec);
    int k;
    k = 0;
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      k++;
    end while (rd[`STAT_BUSY_BIT] !== 1'b0 && k < 100);
    chk(rd[`STAT_BUSY_BIT], 1'b0);
    chk(rd[`STAT_UNIT_CHK_BIT], ec);
    apb(1'b0, `OFS_SENSE0, 32'h0);
    chk(rd[`SENSE0_CONV_CHK_BIT], ec);
    chk(IRQ, ec);
    apb(1'b1, `OFS_IRQ_STAT, 32'h3);
    chk(IRQ, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_wr(input logic [3:0] ctl, input int n, input logic cv);
    logic [23:0] acc;
    int x;
    int nch;
    x = 0;
    // leftover bytes give one character more than their count
    nch = cv ? n / 3 * 4 + (n % 3 != 0 ? n % 3 + 1 : 0) : n;
    cq.delete();
    apb(1'b1, `OFS_CTRL, {28'h0, ctl});
    BYTE_IN_VALID <= 1'b1;
    for (int i = 0; i < n; i++) begin
      BYTE_IN_DATA <= bs[i];
      BYTE_IN_LAST <= (i == n - 1);
      do @(posedge CLK_SYS); while (!BYTE_IN_READY);
    end
    BYTE_IN_VALID <= 1'b0;
    post(1'b0);
    for (int g = 0; g < n; g += (cv ? 3 : 1)) begin
      acc = 24'h0;
      for (int j = 0; j < 3 && g + j < n; j++) acc[23 - 8 * j -: 8] = bs[g + j];
      // pad bits stay zero in acc
      for (int k = 0; k < (cv ? ((n - g > 3 ? 3 : n - g) * 8 + 5) / 6 : 1); k++) begin
        chk(cq[x], {x == nch - 1, cv ? acc[23 - 6 * k -: 6] : bs[g][5:0]});
        x++;
      end
    end
    chk(cq.size(), x);
  endtask
  task automatic run_rd(input logic [3:0] ctl, input int n, input logic cv, input logic ec);
    logic [23:0] acc;
    int x;
    int nb;
    logic lz;
    x = 0;
    // a lone trailing character yields no byte, so no last flag at all
    nb = cv ? n / 4 * 3 + (n % 4 > 1 ? n % 4 - 1 : 0) : n;
    lz = cv && (n % 4 == 1);
    bq.delete();
    apb(1'b1, `OFS_CTRL, {28'h0, ctl});
    CHAR_IN_VALID <= 1'b1;
    for (int i = 0; i < n; i++) begin
      CHAR_IN_DATA <= cs[i];
      CHAR_IN_LAST <= (i == n - 1);
      do @(posedge CLK_SYS); while (!CHAR_IN_READY);
    end
    CHAR_IN_VALID <= 1'b0;
    post(ec);
    for (int g = 0; g < n; g += (cv ? 4 : 1)) begin
      acc = 24'h0;
      for (int j = 0; j < 4 && g + j < n; j++) acc[23 - 6 * j -: 6] = cs[g + j];
      for (int k = 0; k < (cv ? (n - g > 4 ? 4 : n - g) * 6 / 8 : 1); k++) begin
        chk(bq[x], {x == nb - 1 && !lz, cv ? acc[23 - 8 * k -: 8] : {2'b00, cs[g]}});
        x++;
      end
    end
    chk(bq.size(), x);
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge CLK_SYS);
    SRST <= 1'b0;
    @(posedge CLK_SYS);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(perr, 1'b1);
    apb(1'b1, `OFS_IRQ_MASK, 32'h2);
    run_wr(4'h7, 6, 1'b1);
    slow <= 1'b1;
    run_wr(4'h7, 4, 1'b1);
    run_wr(4'h7, 5, 1'b1);
    run_wr(4'h5, 3, 1'b0);
    run_wr(4'h6, 2, 1'b0);
    run_rd(4'hf, 5, 1'b0, 1'b0);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h3);
    run_rd(4'hb, 8, 1'b1, 1'b0);
    slow <= 1'b0;
    run_rd(4'hb, 5, 1'b1, 1'b1);
    run_rd(4'hb, 6, 1'b1, 1'b0);
    cs[5] = 6'h31;
    run_rd(4'hb, 6, 1'b1, 1'b1);
    run_rd(4'hb, 7, 1'b1, 1'b0);
    cs[6] = 6'h22;
    run_rd(4'hb, 7, 1'b1, 1'b1);
    run_rd(4'h9, 5, 1'b0, 1'b0);
    report_and_stop;
  end
  initial begin
    #100000;
    err_total++;
    report_and_stop;
  end
endmodule // seven_track_byte_packer_tb_top
`default_nettype wire
